// >>> src/cld_regs.vh
// constants for the cold load detector: register map, field positions,
// reset values and timing figures. assumes a 20 MHz pclk and APB access.
`ifndef CLD_REGS_VH
`define CLD_REGS_VH

// register byte offsets
`define CLD_OFF_CTRL 8'h00
`define CLD_OFF_GROUP 8'h04
`define CLD_OFF_G0_LOW 8'h10
`define CLD_OFF_G0_HIGH 8'h14
`define CLD_OFF_G0_OVER 8'h18
`define CLD_OFF_G1_LOW 8'h1C
`define CLD_OFF_G1_HIGH 8'h20
`define CLD_OFF_G1_OVER 8'h24
`define CLD_OFF_T_START 8'h28
`define CLD_OFF_T_MAX 8'h2C
`define CLD_OFF_T_MIN 8'h30
`define CLD_OFF_STATUS 8'h34

// field positions
`define CLD_CTRL_MODE_LSB 0
`define CLD_CTRL_SIDE_BIT 4
`define CLD_STAT_COND_LSB 0
`define CLD_STAT_BEHAV_LSB 4
`define CLD_STAT_ACT_BIT 8
`define CLD_STAT_BLK_BIT 9

// operating modes
`define CLD_MODE_ON 3'h0
`define CLD_MODE_BLOCKED 3'h1
`define CLD_MODE_TEST 3'h2
`define CLD_MODE_TEST_BLK 3'h3
`define CLD_MODE_OFF 3'h4

// condition codes
`define CLD_COND_NORMAL 3'h0
`define CLD_COND_LOW 3'h1
`define CLD_COND_OVER 3'h2
`define CLD_COND_ACTIVE 3'h3
`define CLD_COND_BLOCKED 3'h4

// thresholds in 0.01 per-unit steps
`define CLD_RST_LOW 16'h0014
`define CLD_RST_HIGH 16'h0078
`define CLD_RST_OVER 16'h00C8
`define CLD_RESET_PCT 97
`define CLD_FULL_PCT 100

// timing: pclk rate, processing cycle and timer defaults
`define CLD_PCLK_HZ 20000000
`define CLD_CYCLE_MS 5
`define CLD_CYCLE_CLKS ((`CLD_PCLK_HZ / 1000) * `CLD_CYCLE_MS)
`define CLD_T_START_MS 10000
`define CLD_T_MAX_MS 30000
`define CLD_T_MIN_MS 40
// default delays counted in processing cycles, sized to the timer width
`define CLD_RST_T_START 20'h007D0
`define CLD_RST_T_MAX 20'h01770
`define CLD_RST_T_MIN 20'h00008

`endif

// >>> src/cld_phase_cmp.v
// one phase of threshold comparison with hysteresis for the cold load block.
// assumes magnitudes are fundamental-only values in 0.01 per-unit steps.
`timescale 1ns/1ns
`default_nettype none

module cld_phase_cmp #(
   parameter MW = 16
) (
   // clock and reset
   input wire pclk,
   input wire presetn,
   // evaluate strobe, one per processing cycle
   input wire eval,
   // phase magnitude and shared thresholds
   input wire [MW-1:0] mag,
   input wire [MW-1:0] th_low,
   input wire [MW-1:0] th_high,
   input wire [MW-1:0] th_over,
   // per-phase conditions
   output reg below_q,
   output reg above_q,
   output reg over_q
);

`include "cld_regs.vh"

   localparam W = MW + 7;
   localparam [6:0] FULL_PCT = `CLD_FULL_PCT;
   localparam [6:0] RST_PCT = `CLD_RESET_PCT;

   // scaled values: compare m*100 against thr*97 so no divider is needed
   wire [W-1:0] mag_x100 = mag * FULL_PCT;

   function [W-1:0] rel_level;
      input [MW-1:0] thr;
      begin
         rel_level = thr * RST_PCT;
      end
   endfunction

   function [W-1:0] full_level;
      input [MW-1:0] thr;
      begin
         full_level = thr * FULL_PCT;
      end
   endfunction

   // an over-type flag sets above thr and only drops below 97 % of it
   function above_next;
      input cur;
      input [W-1:0] m;
      input [MW-1:0] thr;
      begin
         if (m > full_level(thr)) begin
            above_next = 1'b1;
         end else if (m < rel_level(thr)) begin
            above_next = 1'b0;
         end else begin
            above_next = cur;
         end
      end
   endfunction

   // conditions move only on the evaluate strobe
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         below_q <= 1'b0;
         above_q <= 1'b0;
         over_q <= 1'b0;
      end else if (eval) begin
         // low flag sets under 97 % and clears at the setting
         if (mag_x100 < rel_level(th_low)) begin
            below_q <= 1'b1;
         end else if (mag_x100 >= full_level(th_low)) begin
            below_q <= 1'b0;
         end
         above_q <= above_next(above_q, mag_x100, th_high);
         over_q <= above_next(over_q, mag_x100, th_over);
      end
   end

endmodule

`default_nettype wire

// >>> src/cld_detector.v
// cold load detector: phase thresholds, start/min/max timers, blocking and
// an APB register file. assumes a 20 MHz pclk and magnitudes synchronous to it.
`timescale 1ns/1ns
`default_nettype none
`include "cld_regs.vh"

//////////////////////////////////////////////////////////////////////////////

module cld_detector #(
   parameter MW = 16,
   parameter TW = 20,
   parameter CYCLE_CLKS = `CLD_CYCLE_CLKS
) (
   // clock and reset
   input wire pclk,
   input wire presetn,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // fundamental magnitudes from both measurement sides
   input wire [MW-1:0] side1_phase_a_magnitude,
   input wire [MW-1:0] side1_phase_b_magnitude,
   input wire [MW-1:0] side1_phase_c_magnitude,
   input wire [MW-1:0] side2_phase_a_magnitude,
   input wire [MW-1:0] side2_phase_b_magnitude,
   input wire [MW-1:0] side2_phase_c_magnitude,
   // blocking matrix input
   input wire block_in,
   // indications
   output reg cold_load_active_out,
   output reg cold_load_blocked_out
);

   localparam ST_IDLE = 2'h0;
   localparam ST_ACT = 2'h1;
   localparam ST_BLK = 2'h2;
   localparam CW = 20;

   //////////////////////////////////////////////////////////////////////////
   // settings and APB slave

   reg [2:0] mode_q;
   reg side_q;
   reg group_q;
   reg [MW-1:0] th_low_q [0:1];
   reg [MW-1:0] th_high_q [0:1];
   reg [MW-1:0] th_over_q [0:1];
   reg [TW-1:0] t_start_q;
   reg [TW-1:0] t_max_q;
   reg [TW-1:0] t_min_q;
   reg [2:0] cond_q;
   reg [1:0] st_q;

   wire acc = psel & penable & ~pready;
   wire wr_now = psel & penable & pready & pwrite;

   function mapped;
      input [7:0] a;
      begin
         mapped = (a <= `CLD_OFF_STATUS) && (a[1:0] == 2'b00) &&
            !(a > `CLD_OFF_GROUP && a < `CLD_OFF_G0_LOW);
      end
   endfunction

   // one wait state so read data can come straight from a flop
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= acc;
         pslverr <= acc & ~mapped(paddr);
         prdata <= 32'h00000000;
         if (acc && !pwrite) begin
            if (paddr == `CLD_OFF_CTRL) begin
               prdata <= {27'h0000000, side_q, 1'b0, mode_q};
            end else if (paddr == `CLD_OFF_GROUP) begin
               prdata <= {31'h00000000, group_q};
            end else if (paddr == `CLD_OFF_G0_LOW) begin
               prdata <= {{(32-MW){1'b0}}, th_low_q[0]};
            end else if (paddr == `CLD_OFF_G0_HIGH) begin
               prdata <= {{(32-MW){1'b0}}, th_high_q[0]};
            end else if (paddr == `CLD_OFF_G0_OVER) begin
               prdata <= {{(32-MW){1'b0}}, th_over_q[0]};
            end else if (paddr == `CLD_OFF_G1_LOW) begin
               prdata <= {{(32-MW){1'b0}}, th_low_q[1]};
            end else if (paddr == `CLD_OFF_G1_HIGH) begin
               prdata <= {{(32-MW){1'b0}}, th_high_q[1]};
            end else if (paddr == `CLD_OFF_G1_OVER) begin
               prdata <= {{(32-MW){1'b0}}, th_over_q[1]};
            end else if (paddr == `CLD_OFF_T_START) begin
               prdata <= {{(32-TW){1'b0}}, t_start_q};
            end else if (paddr == `CLD_OFF_T_MAX) begin
               prdata <= {{(32-TW){1'b0}}, t_max_q};
            end else if (paddr == `CLD_OFF_T_MIN) begin
               prdata <= {{(32-TW){1'b0}}, t_min_q};
            end else if (paddr == `CLD_OFF_STATUS) begin
               // behaviour mirrors the configured mode register, not the block input
               prdata <= {22'h000000, (st_q == ST_BLK), (st_q == ST_ACT),
                  1'b0, mode_q, 1'b0, cond_q};
            end
         end
      end
   end

   // register writes land at the edge that completes the transfer
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= `CLD_MODE_ON;
         side_q <= 1'b0;
         group_q <= 1'b0;
         th_low_q[0] <= `CLD_RST_LOW;
         th_high_q[0] <= `CLD_RST_HIGH;
         th_over_q[0] <= `CLD_RST_OVER;
         th_low_q[1] <= `CLD_RST_LOW;
         th_high_q[1] <= `CLD_RST_HIGH;
         th_over_q[1] <= `CLD_RST_OVER;
         t_start_q <= `CLD_RST_T_START;
         t_max_q <= `CLD_RST_T_MAX;
         t_min_q <= `CLD_RST_T_MIN;
      end else if (wr_now) begin
         if (paddr == `CLD_OFF_CTRL) begin
            // mode and side live outside the groups
            if (pwdata[2:0] <= `CLD_MODE_OFF) begin
               mode_q <= pwdata[2:0];
            end
            side_q <= pwdata[`CLD_CTRL_SIDE_BIT];
         end else if (paddr == `CLD_OFF_GROUP) begin
            group_q <= pwdata[0];
         end else if (paddr == `CLD_OFF_G0_LOW) begin
            th_low_q[0] <= pwdata[MW-1:0];
         end else if (paddr == `CLD_OFF_G0_HIGH) begin
            th_high_q[0] <= pwdata[MW-1:0];
         end else if (paddr == `CLD_OFF_G0_OVER) begin
            th_over_q[0] <= pwdata[MW-1:0];
         end else if (paddr == `CLD_OFF_G1_LOW) begin
            th_low_q[1] <= pwdata[MW-1:0];
         end else if (paddr == `CLD_OFF_G1_HIGH) begin
            th_high_q[1] <= pwdata[MW-1:0];
         end else if (paddr == `CLD_OFF_G1_OVER) begin
            th_over_q[1] <= pwdata[MW-1:0];
         end else if (paddr == `CLD_OFF_T_START) begin
            t_start_q <= pwdata[TW-1:0];
         end else if (paddr == `CLD_OFF_T_MAX) begin
            t_max_q <= pwdata[TW-1:0];
         end else if (paddr == `CLD_OFF_T_MIN) begin
            t_min_q <= pwdata[TW-1:0];
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // processing-cycle tick and block sampling

   reg [CW-1:0] div_q;
   reg tick_q;
   reg eval_q;
   reg blk_s_q;

   // tick starts a cycle; evaluation follows one clock later on fresh flags
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q <= {CW{1'b0}};
         tick_q <= 1'b0;
         eval_q <= 1'b0;
         blk_s_q <= 1'b0;
      end else begin
         tick_q <= (div_q == CYCLE_CLKS[CW-1:0] - 1'b1);
         div_q <= (div_q == CYCLE_CLKS[CW-1:0] - 1'b1) ? {CW{1'b0}} : div_q + 1'b1;
         eval_q <= tick_q;
         if (tick_q) begin
            blk_s_q <= block_in;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // phase comparators

   wire [MW-1:0] mag [0:2];
   wire [2:0] below;
   wire [2:0] above;
   wire [2:0] over;

   // side select feeds all three phases
   assign mag[0] = side_q ? side2_phase_a_magnitude : side1_phase_a_magnitude;
   assign mag[1] = side_q ? side2_phase_b_magnitude : side1_phase_b_magnitude;
   assign mag[2] = side_q ? side2_phase_c_magnitude : side1_phase_c_magnitude;

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_ph
         cld_phase_cmp #(.MW(MW)) u_cmp (
            .pclk(pclk),
            .presetn(presetn),
            .eval(tick_q),
            .mag(mag[gi]),
            .th_low(th_low_q[group_q]),
            .th_high(th_high_q[group_q]),
            .th_over(th_over_q[group_q]),
            .below_q(below[gi]),
            .above_q(above[gi]),
            .over_q(over[gi])
         );
      end
   endgenerate

   wire low_all = &below;
   wire high_all = &above;
   wire over_any = |over;

   //////////////////////////////////////////////////////////////////////////
   // pick-up state machine and timers

   reg [TW-1:0] start_cnt_q;
   reg [TW-1:0] min_cnt_q;
   reg [TW-1:0] max_cnt_q;
   reg [1:0] st_d;

   wire mode_off = (mode_q == `CLD_MODE_OFF);
   wire mode_test = (mode_q == `CLD_MODE_TEST) || (mode_q == `CLD_MODE_TEST_BLK);
   wire blk_eff = blk_s_q || (mode_q == `CLD_MODE_BLOCKED) ||
      (mode_q == `CLD_MODE_TEST_BLK);
   wire min_done = (min_cnt_q >= t_min_q);

   // next state on each evaluation
   always @* begin
      st_d = st_q;
      if (mode_off) begin
         st_d = ST_IDLE;
      end else if (eval_q) begin
         case (st_q)
            ST_IDLE: begin
               // low must persist the start delay
               if (low_all && start_cnt_q >= t_start_q) begin
                  st_d = blk_eff ? ST_BLK : ST_ACT;
               end
            end
            ST_ACT: begin
               if (over_any || blk_eff) begin
                  st_d = ST_IDLE;
               end else if (high_all && max_cnt_q + 1'b1 >= t_max_q) begin
                  st_d = ST_IDLE;
               end else if (!high_all && !low_all && min_done) begin
                  st_d = ST_IDLE;
               end
            end
            ST_BLK: begin
               // no further processing until the low condition ends
               if (!low_all) begin
                  st_d = ST_IDLE;
               end
            end
            default: st_d = ST_IDLE;
         endcase
      end
   end

   // timers advance once per processing cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= ST_IDLE;
         start_cnt_q <= {TW{1'b0}};
         min_cnt_q <= {TW{1'b0}};
         max_cnt_q <= {TW{1'b0}};
         cond_q <= `CLD_COND_NORMAL;
         cold_load_active_out <= 1'b0;
         cold_load_blocked_out <= 1'b0;
      end else begin
         st_q <= st_d;
         // test modes run the logic but keep the active output quiet; the blocked output still follows
         cold_load_active_out <= (st_d == ST_ACT) && !mode_test;
         cold_load_blocked_out <= (st_d == ST_BLK);
         if (mode_off || (eval_q && st_d != st_q)) begin
            start_cnt_q <= {TW{1'b0}};
            min_cnt_q <= {TW{1'b0}};
            max_cnt_q <= {TW{1'b0}};
         end else if (eval_q) begin
            if (st_q == ST_IDLE) begin
               start_cnt_q <= low_all ? start_cnt_q + 1'b1 : {TW{1'b0}};
            end
            if (st_q == ST_ACT) begin
               if (!min_done) begin
                  min_cnt_q <= min_cnt_q + 1'b1;
               end
               max_cnt_q <= high_all ? max_cnt_q + 1'b1 : {TW{1'b0}};
            end
         end
         // condition report
         if (mode_off) begin
            cond_q <= `CLD_COND_NORMAL;
         end else if (st_d == ST_ACT) begin
            cond_q <= `CLD_COND_ACTIVE;
         end else if (st_d == ST_BLK) begin
            cond_q <= `CLD_COND_BLOCKED;
         end else if (over_any) begin
            cond_q <= `CLD_COND_OVER;
         end else if (low_all) begin
            cond_q <= `CLD_COND_LOW;
         end else begin
            cond_q <= `CLD_COND_NORMAL;
         end
      end
   end

endmodule

`default_nettype wire

// >>> testbench/cld_assertions.sv
// checker for the cold load detector, watching only the top-level ports.
// assumes the bench holds block_in steady over several processing cycles.
`timescale 1ns/1ns
`default_nettype none

module cld_assertions #(
   parameter CYCLE_CLKS = 20
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // blocking and indications
   input wire logic block_in,
   input wire logic cold_load_active_out,
   input wire logic cold_load_blocked_out
);
   // one tick plus output latency, with a small margin for tick phase
   localparam int LIM = CYCLE_CLKS + 4;
   logic unm;

   // holes, unaligned and past-the-end offsets are not mapped
   assign unm = (paddr[1:0] != 2'h0) || (paddr > 8'h34) || (paddr == 8'h08) || (paddr == 8'h0C);

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   //////////////////////////////////////////////////////////////////////////
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held longer than one cycle");
   a_ready_wait: assert property (psel && penable && !$past(penable) |=> pready)
      else $error("pready not one cycle after access start");
   a_err_decode: assert property (pready |-> (pslverr == unm))
      else $error("pslverr does not match address decode");
   a_rdata_idle: assert property (!pready |-> (prdata == 32'h0))
      else $error("prdata not zero outside a completion");
   a_post_reset: assert property (!$past(presetn) |-> !cold_load_active_out && !cold_load_blocked_out)
      else $error("indication high right after reset");
   a_act_blk_excl: assert property (!(cold_load_active_out && cold_load_blocked_out))
      else $error("active and blocked at once");
   a_block_drops: assert property (block_in && cold_load_active_out |-> ##[1:LIM] !cold_load_active_out)
      else $error("blocking did not release activation");
   a_act_hold: assert property ($rose(cold_load_active_out) |=> cold_load_active_out [*8])
      else $error("activation changed between processing cycles");
endmodule

bind cld_detector cld_assertions #(.CYCLE_CLKS(CYCLE_CLKS)) u_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .block_in(block_in), .cold_load_active_out(cold_load_active_out),
   .cold_load_blocked_out(cold_load_blocked_out));

`default_nettype wire

// >>> testbench/cld_front_end.sv
// model of the two measurement sides and the blocking matrix.
// assumes the bench sets targets just after a rising pclk edge.
`timescale 1ns/1ns
`default_nettype none

module cld_front_end (
   // clock
   input wire logic pclk,
   // targets: side one a,b,c then side two a,b,c
   input wire logic [15:0] tgt [6],
   input wire logic blk_t,
   // towards the detector
   output var logic [15:0] mag [6],
   output var logic block_in
);
   // defined levels from time zero so reset never sees unknowns
   initial begin
      mag = '{default: 16'h0032};
      block_in = 1'b0;
   end

   // fundamental magnitudes stream every clock; block_in follows blk_t with the same one-clock delay
   always @(posedge pclk) begin
      mag <= tgt;
      block_in <= blk_t;
   end
endmodule

`default_nettype wire

// >>> testbench/cld_detector_tb.sv
// self-checking bench for the cold load detector over apb and a front end model.
// assumes a 50 ns pclk and a shortened processing cycle of 20 clocks.
`timescale 1ns/1ns
`default_nettype none

module cld_detector_tb;
   localparam int CYC = 20;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, blk = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, r, lf = 32'hE382;
   logic pready, pslverr, e, act, bo, blkd;
   logic [15:0] tgt [6], mag [6];
   int fails = 0, checked = 0;
   int mdl [int];

   always #25 pclk = ~pclk;

   //////////////////////////////////////////////////////////////////////////
   cld_front_end u_fe (.pclk(pclk), .tgt(tgt), .blk_t(blk), .mag(mag), .block_in(blkd));
   cld_detector #(.CYCLE_CLKS(CYC)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .side1_phase_a_magnitude(mag[0]),
      .side1_phase_b_magnitude(mag[1]), .side1_phase_c_magnitude(mag[2]),
      .side2_phase_a_magnitude(mag[3]), .side2_phase_b_magnitude(mag[4]),
      .side2_phase_c_magnitude(mag[5]), .block_in(blkd), .cold_load_active_out(act),
      .cold_load_blocked_out(bo));

   //////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      checked++;
      if (s !== x) begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, s, x);
      end
   endtask

   task automatic final_report();
      if (fails == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // one apb transfer; an idle edge follows so strobes are never reassigned in one step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) begin
         fails++;
         final_report();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // writes keep the register mirror; an out-of-range mode is not taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      if (!(a == 8'h00 && d[2:0] > 3'h4)) mdl[a] = d;
   endtask

   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
      chk(r, mdl[a]);
   endtask

   task automatic st(input logic [2:0] c, input logic a);
      apb(1'b0, 8'h34, 32'h0);
      chk(r[2:0], c);
      chk(r[9:8], {1'b0, a});
      chk(act, a);
   endtask

   // set side one magnitudes, then let t processing cycles pass
   task automatic mg(input int x, input int y, input int z, input int t);
      tgt[0] <= 16'(x);
      tgt[1] <= 16'(y);
      tgt[2] <= 16'(z);
      repeat (t * CYC) @(posedge pclk);
   endtask

   //////////////////////////////////////////////////////////////////////////
   initial begin
      logic [7:0] ro [9];
      logic [7:0] um [3];
      int rv [9];
      ro = '{8'h00, 8'h04, 8'h10, 8'h14, 8'h18, 8'h28, 8'h2C, 8'h30, 8'h34};
      rv = '{0, 0, 20, 120, 200, 2000, 6000, 8, 0};
      um = '{8'h08, 8'h3C, 8'h01};
      tgt = '{default: 16'h0032};
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      foreach (ro[i]) begin
         mdl[ro[i]] = rv[i];
         rd(ro[i]);
      end
      foreach (um[i]) begin
         apb(i == 1, um[i], 32'hFF);
         chk(e, 1'b1);
         chk(r, 32'h0);
      end
      wr(8'h28, 3);
      wr(8'h2C, 5);
      wr(8'h30, 2);
      mg(20, 20, 20, 7);
      chk(act, 1'b0);
      mg(19, 19, 25, 7);
      chk(act, 1'b0);
      mg(19, 19, 19, 2);
      st(1, 0);
      mg(19, 19, 19, 5);
      st(3, 1);
      mg(250, 19, 19, 2);
      st(2, 0);
      mg(10, 10, 10, 7);
      mg(150, 150, 150, 2);
      chk(act, 1'b1);
      mg(150, 150, 150, 8);
      chk(act, 1'b0);
      mg(10, 10, 10, 7);
      mg(50, 50, 50, 6);
      chk(act, 1'b0);
      mg(10, 10, 10, 7);
      blk <= 1'b1;
      mg(10, 10, 10, 2);
      chk(act, 1'b0);
      mg(50, 50, 50, 2);
      mg(10, 10, 10, 7);
      chk(bo, 1'b1);
      chk(act, 1'b0);
      blk <= 1'b0;
      mg(50, 50, 50, 2);
      // side two stays normal while side one goes low, then the other way round
      wr(8'h00, 32'h10);
      mg(10, 10, 10, 7);
      chk(act, 1'b0);
      for (int i = 3; i < 6; i++) tgt[i] <= 16'h000A;
      mg(50, 50, 50, 7);
      chk(act, 1'b1);
      for (int i = 3; i < 6; i++) tgt[i] <= 16'h0032;
      wr(8'h00, 0);
      mg(50, 50, 50, 4);
      wr(8'h1C, 40);
      wr(8'h20, 120);
      wr(8'h24, 200);
      wr(8'h04, 1);
      rd(8'h00);
      mg(30, 30, 30, 7);
      chk(act, 1'b1);
      wr(8'h04, 0);
      mg(50, 50, 50, 4);
      for (int m = 0; m < 5; m++) begin
         wr(8'h00, m);
         rd(8'h00);
         mg(10, 10, 10, 7);
         apb(1'b0, 8'h34, 32'h0);
         chk(r[6:4], m);
         chk(r[2:0], m[0] ? 3'h4 : ((m == 4) ? 3'h0 : 3'h3));
         chk(act, m == 0);
         mg(50, 50, 50, 4);
      end
      wr(8'h00, 5);
      rd(8'h00);
      wr(8'h00, 0);
      for (int i = 0; i < 4; i++) begin
         lf = lfsr(lf);
         mg(60 + lf[4:0], 60 + lf[9:5], 60 + lf[14:10], 2);
         chk(act, 1'b0);
      end
      final_report();
   end
endmodule

`default_nettype wire
